// *** verilog/dmaal_pkg.sv ***
// Constants and types for the channel register alias decoder
//
// Summary of operation
// - Set one: control 0x010, source 0x014, dest 0x018, count 0x01C; 0x40 per channel.
// - Set one count word triggers: stores count, nonzero write reloads and starts channel.
// - Set two: control 0x020, count 0x024, source 0x028, dest 0x02C trigger.
// - Set three: control 0x030, dest 0x034, count 0x038, source 0x03C trigger.
// - Trigger is the last word (0xC) of each set; nonzero write starts channel.
// - Alias words are 32-bit views of primary storage, no own reset value.
// - Set one source alias at 0x014 plus 0x40 per channel, up to 0x2D4.
// - Quiet mode: zero write to a trigger raises the channel interrupt instead.
// - Triggers start the channel only while enable is set; clearing enable pauses.
package dmaal_pkg;
	localparam int DMAAL_AW = 10;
	localparam int DMAAL_CHANNELS = 12;
	localparam logic [6:0] DMAAL_STRIDE = 7'h40;
	localparam logic [3:0] DMAAL_TRIG_WORD = 4'hC;
	localparam logic [5:0] DMAAL_OFF_CTRL = 6'h00;
	localparam logic [5:0] DMAAL_OFF_SRC = 6'h04;
	localparam logic [5:0] DMAAL_OFF_DST = 6'h08;
	localparam logic [5:0] DMAAL_OFF_CNT = 6'h0C;
	localparam logic [5:0] DMAAL_ALIAS_SET_ONE_CTRL = 6'h10;
	localparam logic [5:0] DMAAL_ALIAS_SET_ONE_SRC = 6'h14;
	localparam logic [5:0] DMAAL_ALIAS_SET_ONE_DST = 6'h18;
	localparam logic [5:0] DMAAL_ALIAS_SET_ONE_CNT = 6'h1C;
	localparam logic [5:0] DMAAL_ALIAS_SET_TWO_CTRL = 6'h20;
	localparam logic [5:0] DMAAL_ALIAS_SET_TWO_CNT = 6'h24;
	localparam logic [5:0] DMAAL_ALIAS_SET_TWO_SRC = 6'h28;
	localparam logic [5:0] DMAAL_ALIAS_SET_TWO_DST = 6'h2C;
	localparam logic [5:0] DMAAL_ALIAS_SET_THREE_CTRL = 6'h30;
	localparam logic [5:0] DMAAL_ALIAS_SET_THREE_DST = 6'h34;
	localparam logic [5:0] DMAAL_ALIAS_SET_THREE_CNT = 6'h38;
	localparam logic [5:0] DMAAL_ALIAS_SET_THREE_SRC = 6'h3C;
	localparam logic [9:0] DMAAL_IRQ_STATUS = 10'h300;
	localparam logic [9:0] DMAAL_IRQ_MASK = 10'h304;
	localparam logic [9:0] DMAAL_BUSY_STATUS = 10'h308;
	localparam int DMAAL_EN_BIT = 0;
	localparam int DMAAL_QUIET_BIT = 21;
	localparam int DMAAL_BUSY_BIT = 24;
	localparam logic [31:0] DMAAL_CTRL_RESET = 32'h0000_0000;
	localparam logic [31:0] DMAAL_PTR_RESET = 32'h0000_0000;
	localparam int DMAAL_CHAIN_LSB = 11;

	typedef enum logic [1:0] {
		DMAAL_FIELD_CTRL = 2'h0,
		DMAAL_FIELD_SRC = 2'h1,
		DMAAL_FIELD_DST = 2'h2,
		DMAAL_FIELD_CNT = 2'h3
	} dmaal_field_type;

	typedef enum logic [1:0] {
		DMAAL_ST_IDLE = 2'b00,
		DMAAL_ST_RUN = 2'b01,
		DMAAL_ST_PAUSE = 2'b11
	} dmaal_state_type;
endpackage : dmaal_pkg

// *** verilog/dmaal_decode.sv ***
// Word decoder: maps a block offset to register field and trigger flag
`timescale 1ns/1ps
module dmaal_decode
	import dmaal_pkg::*;
(
	input wire logic [5:0] offset,
	output dmaal_field_type field,
	output logic is_trigger,
	output logic is_alias
);
	logic [5:0] word_off;

	// Byte lanes within a word carry no meaning here
	assign word_off = {offset[5:2], 2'b00};

	always_comb begin
		field = DMAAL_FIELD_CTRL;
		if (word_off == DMAAL_ALIAS_SET_ONE_SRC || word_off == DMAAL_OFF_SRC) begin
			field = DMAAL_FIELD_SRC;
		end else if (word_off == DMAAL_ALIAS_SET_ONE_DST || word_off == DMAAL_OFF_DST) begin
			field = DMAAL_FIELD_DST;
		end else if (word_off == DMAAL_ALIAS_SET_ONE_CNT || word_off == DMAAL_OFF_CNT) begin
			field = DMAAL_FIELD_CNT;
		end else if (word_off == DMAAL_ALIAS_SET_TWO_CNT) begin
			field = DMAAL_FIELD_CNT;
		end else if (word_off == DMAAL_ALIAS_SET_TWO_SRC) begin
			field = DMAAL_FIELD_SRC;
		end else if (word_off == DMAAL_ALIAS_SET_TWO_DST) begin
			field = DMAAL_FIELD_DST;
		end else if (word_off == DMAAL_ALIAS_SET_THREE_DST) begin
			field = DMAAL_FIELD_DST;
		end else if (word_off == DMAAL_ALIAS_SET_THREE_CNT) begin
			field = DMAAL_FIELD_CNT;
		end else if (word_off == DMAAL_ALIAS_SET_THREE_SRC) begin
			field = DMAAL_FIELD_SRC;
		end
	end

	// any alias word; the trigger is the last word of an alias set
	assign is_alias = (word_off[5:4] != 2'h0);
	assign is_trigger = is_alias && (word_off[3:0] == DMAAL_TRIG_WORD);
endmodule : dmaal_decode

// *** verilog/dmaal_channel.sv ***
// One channel's storage, trigger handling and run state
`timescale 1ns/1ps
module dmaal_channel
	import dmaal_pkg::*;
#(
	parameter logic [3:0] CHAN_ID = 4'h0
)
(
	input wire logic clk_sys,
	input wire logic resetn,
	input wire logic wr_en,
	input dmaal_field_type wr_field,
	input wire logic wr_trigger,
	input wire logic [31:0] wr_data,
	input wire logic done,
	output logic [31:0] ctrl_q,
	output logic [31:0] src_q,
	output logic [31:0] dst_q,
	output logic [31:0] cnt_q,
	output logic [31:0] counter_q,
	output logic busy,
	output logic start_pulse,
	output logic null_pulse
);
	dmaal_state_type state_q;
	logic en;
	logic quiet;
	logic trig_write;

	assign en = ctrl_q[DMAAL_EN_BIT];
	assign quiet = ctrl_q[DMAAL_QUIET_BIT];
	assign trig_write = wr_en && wr_trigger;
	// nonzero trigger starts only when enabled
	assign start_pulse = trig_write && (wr_data != 32'h0000_0000) &&
		(wr_field == DMAAL_FIELD_CTRL ? wr_data[DMAAL_EN_BIT] : en);
	assign null_pulse = trig_write && (wr_data == 32'h0000_0000) && quiet;
	assign busy = (state_q != DMAAL_ST_IDLE);

	// shared storage, plain writes never start
	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			ctrl_q <= DMAAL_CTRL_RESET | (32'(CHAN_ID) << DMAAL_CHAIN_LSB);
			src_q <= DMAAL_PTR_RESET;
			dst_q <= DMAAL_PTR_RESET;
			cnt_q <= DMAAL_PTR_RESET;
		end else if (wr_en) begin
			case (wr_field)
				DMAAL_FIELD_CTRL: begin
					ctrl_q <= wr_data;
				end
				DMAAL_FIELD_SRC: begin
					src_q <= wr_data;
				end
				DMAAL_FIELD_DST: begin
					dst_q <= wr_data;
				end
				default: begin
					cnt_q <= wr_data;
				end
			endcase
		end
	end

	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			counter_q <= DMAAL_PTR_RESET;
		end else if (start_pulse) begin
			counter_q <= (wr_field == DMAAL_FIELD_CNT) ? wr_data : cnt_q;
		end else if (state_q == DMAAL_ST_RUN && done && counter_q != 32'h0000_0000) begin
			counter_q <= counter_q - 32'h0000_0001;
		end
	end

	// enable low pauses a running sequence
	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			state_q <= DMAAL_ST_IDLE;
		end else begin
			case (state_q)
				DMAAL_ST_IDLE: begin
					if (start_pulse) begin
						state_q <= DMAAL_ST_RUN;
					end
				end
				DMAAL_ST_RUN: begin
					// A restart in the completing cycle keeps the channel running
					if (start_pulse) begin
						state_q <= DMAAL_ST_RUN;
					end else if (done && counter_q <= 32'h0000_0001) begin
						state_q <= DMAAL_ST_IDLE;
					end else if (!en) begin
						state_q <= DMAAL_ST_PAUSE;
					end
				end
				default: begin
					if (en) begin
						state_q <= DMAAL_ST_RUN;
					end
				end
			endcase
		end
	end
endmodule : dmaal_channel

// *** verilog/dmaal_top.sv ***
// Register block: twelve channels with primary and alias views
//
// Local design decision: strobed register access.
`timescale 1ns/1ps
module dmaal_top
	import dmaal_pkg::*;
#(
	parameter int CHANNELS = DMAAL_CHANNELS
)
(
	input wire logic clk_sys,
	input wire logic resetn,
	input wire logic [DMAAL_AW-1:0] bus_addr,
	input wire logic [31:0] bus_wdata,
	input wire logic bus_write,
	input wire logic bus_read,
	output logic [31:0] bus_rdata,
	input wire logic [CHANNELS-1:0] xfer_done,
	output logic [CHANNELS-1:0] chan_start,
	output logic [CHANNELS-1:0] chan_busy,
	output logic irq
);
	logic [5:0] offset;
	logic [3:0] chan_sel;
	dmaal_field_type field;
	logic is_trigger;
	logic in_channels;
	logic [CHANNELS-1:0] wr_sel;
	logic [CHANNELS-1:0] null_evt;
	logic [31:0] ctrl_v [CHANNELS];
	logic [31:0] src_v [CHANNELS];
	logic [31:0] dst_v [CHANNELS];
	logic [31:0] cnt_v [CHANNELS];
	logic [CHANNELS-1:0] irq_status_q;
	logic [CHANNELS-1:0] irq_mask_q;
	logic [31:0] rdata_d;
	logic [31:0] rdata_q;

	assign offset = bus_addr[5:0];
	assign chan_sel = bus_addr[9:6];
	assign in_channels = (32'(chan_sel) < CHANNELS);

	dmaal_decode u_decode (
		.offset(offset),
		.field(field),
		.is_trigger(is_trigger),
		.is_alias()
	);

	genvar g;
	generate
		for (g = 0; g < CHANNELS; g++) begin : g_chan
			assign wr_sel[g] = bus_write && in_channels && (chan_sel == 4'(g));
			dmaal_channel #(
				.CHAN_ID(4'(g))
			) u_chan (
				.clk_sys(clk_sys),
				.resetn(resetn),
				.wr_en(wr_sel[g]),
				.wr_field(field),
				.wr_trigger(is_trigger),
				.wr_data(bus_wdata),
				.done(xfer_done[g]),
				.ctrl_q(ctrl_v[g]),
				.src_q(src_v[g]),
				.dst_q(dst_v[g]),
				.cnt_q(cnt_v[g]),
				.counter_q(),
				.busy(chan_busy[g]),
				.start_pulse(chan_start[g]),
				.null_pulse(null_evt[g])
			);
		end
	endgenerate

	// sticky status, set wins over write-one clear
	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			irq_status_q <= '0;
		end else if (bus_write && bus_addr == DMAAL_IRQ_STATUS) begin
			irq_status_q <= (irq_status_q & ~bus_wdata[CHANNELS-1:0]) | null_evt;
		end else begin
			irq_status_q <= irq_status_q | null_evt;
		end
	end

	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			irq_mask_q <= '0;
		end else if (bus_write && bus_addr == DMAAL_IRQ_MASK) begin
			irq_mask_q <= bus_wdata[CHANNELS-1:0];
		end
	end

	assign irq = |(irq_status_q & irq_mask_q);

	always_comb begin
		rdata_d = 32'h0000_0000;
		if (in_channels) begin
			case (field)
				DMAAL_FIELD_CTRL: begin
					rdata_d = ctrl_v[chan_sel];
					rdata_d[DMAAL_BUSY_BIT] = chan_busy[chan_sel];
				end
				DMAAL_FIELD_SRC: begin
					rdata_d = src_v[chan_sel];
				end
				DMAAL_FIELD_DST: begin
					rdata_d = dst_v[chan_sel];
				end
				default: begin
					rdata_d = cnt_v[chan_sel];
				end
			endcase
		end else if (bus_addr == DMAAL_IRQ_STATUS) begin
			rdata_d[CHANNELS-1:0] = irq_status_q;
		end else if (bus_addr == DMAAL_IRQ_MASK) begin
			rdata_d[CHANNELS-1:0] = irq_mask_q;
		end else if (bus_addr == DMAAL_BUSY_STATUS) begin
			rdata_d[CHANNELS-1:0] = chan_busy;
		end
	end

	// Read data valid only in the cycle after the strobe
	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			rdata_q <= 32'h0000_0000;
		end else if (bus_read) begin
			rdata_q <= rdata_d;
		end else begin
			rdata_q <= 32'h0000_0000;
		end
	end

	assign bus_rdata = rdata_q;
endmodule : dmaal_top

// *** sim/dmaal_monitor.sv ***
// Port checker for the alias register block
`timescale 1ns/1ps
module dmaal_monitor
	import dmaal_pkg::*;
#(
	parameter int CHANNELS = DMAAL_CHANNELS
)
(
	input wire logic clk_sys,
	input wire logic resetn,
	input wire logic [DMAAL_AW-1:0] bus_addr,
	input wire logic [31:0] bus_wdata,
	input wire logic bus_write,
	input wire logic bus_read,
	input wire logic [31:0] bus_rdata,
	input wire logic [CHANNELS-1:0] xfer_done,
	input wire logic [CHANNELS-1:0] chan_start,
	input wire logic [CHANNELS-1:0] chan_busy,
	input wire logic irq
);
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!resetn);
	wire logic [3:0] ch = bus_addr[9:6];
	// Last word of alias sets only; the primary count word never starts
	wire logic trig = bus_addr[5:2] inside {4'h7, 4'hB, 4'hF};
	wire logic [CHANNELS-1:0] onehot = CHANNELS'(1) << ch;
	start_cause_a: assert property (chan_start != 0 |-> bus_write && trig && chan_start == onehot)
		else $error("start without a trigger write to that channel");
	nontrig_quiet_a: assert property (bus_write && !trig |-> chan_start == 0)
		else $error("start from a plain alias write");
	zero_no_start_a: assert property (bus_write && bus_wdata == 32'h0 |-> chan_start == 0)
		else $error("start from a zero trigger write");
	start_busy_a: assert property (chan_start != 0 |=> (chan_busy & $past(chan_start)) == $past(chan_start))
		else $error("started channel not busy");
	busy_hold_a: assert property (($past(chan_busy) & ~chan_busy & ~$past(xfer_done)) == 0)
		else $error("busy dropped without completion");
	rdata_idle_a: assert property (!bus_read |=> bus_rdata == 32'h0)
		else $error("read data outside read cycle");
	unmapped_a: assert property (bus_read && ch >= CHANNELS && bus_addr[9:4] != 6'h30 |=> bus_rdata == 32'h0)
		else $error("unmapped read not zero");
	irq_cause_a: assert property ($rose(irq) |-> $past(bus_write))
		else $error("interrupt rose without a write");
endmodule : dmaal_monitor

bind dmaal_top dmaal_monitor #(.CHANNELS(CHANNELS)) u_mon (.clk_sys(clk_sys), .resetn(resetn),
	.bus_addr(bus_addr), .bus_wdata(bus_wdata), .bus_write(bus_write), .bus_read(bus_read),
	.bus_rdata(bus_rdata), .xfer_done(xfer_done), .chan_start(chan_start), .chan_busy(chan_busy), .irq(irq));

// *** sim/dma_channel_alias_decode_bench.sv ***
// Self-checking bench for the alias register block
`timescale 1ns/1ps
module dma_channel_alias_decode_bench;
	import dmaal_pkg::*;
	logic clk_sys = 0, resetn = 0, bus_write = 0, bus_read = 0;
	logic [9:0] bus_addr = 10'h000;
	logic [31:0] bus_wdata = 32'h0, bus_rdata;
	logic [11:0] xfer_done = 12'h000, chan_start, chan_busy;
	logic irq;
	int n_mismatch = 0, comparisons = 0, cyc = 0;
	int unsigned seed = 53228;
	logic [31:0] m [12][4];
	logic [31:0] cntr [12];
	logic [11:0] busy = 12'h000, stat = 12'h000, mask = 12'h000;
	// Field behind each word: ctrl 0, src 1, dst 2, count 3
	int fmap [16] = '{0, 1, 2, 3, 0, 1, 2, 3, 0, 3, 1, 2, 0, 2, 3, 1};
	int tc [3] = '{11, 0, 5};
	logic [5:0] co [3] = '{6'h1C, 6'h24, 6'h38};
	dmaal_top dut (.clk_sys(clk_sys), .resetn(resetn), .bus_addr(bus_addr), .bus_wdata(bus_wdata),
		.bus_write(bus_write), .bus_read(bus_read), .bus_rdata(bus_rdata), .xfer_done(xfer_done),
		.chan_start(chan_start), .chan_busy(chan_busy), .irq(irq));
	always #2 clk_sys = ~clk_sys;
	always @(posedge clk_sys) begin
		cyc++;
		if (cyc == 10000) begin
			n_mismatch++;
			stop_test();
		end
	end
	function logic [31:0] xs();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction : xs
	function logic [31:0] mval(input logic [9:0] a);
		if (a == 10'h300) return {20'h0, stat};
		if (a == 10'h304) return {20'h0, mask};
		if (a == 10'h308) return {20'h0, busy};
		if (a[9:6] > 4'hB) return 32'h0;
		// Busy shows in control bit 24 only
		if (fmap[a[5:2]] == 0) return m[a[9:6]][0] & 32'hFEFF_FFFF | {7'h0, busy[a[9:6]], 24'h0};
		return m[a[9:6]][fmap[a[5:2]]];
	endfunction : mval
	task chk(input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp) begin
			n_mismatch++;
			$display("unexpected at %0t: got %h want %h", $time, got, exp);
		end
	endtask : chk
	task wr(input logic [9:0] a, input logic [31:0] d);
		logic [3:0] c;
		logic t;
		c = a[9:6];
		t = a[3:2] == 2'h3 && a[5:4] != 2'h0 && c < 4'hC;
		@(posedge clk_sys);
		bus_addr <= a;
		bus_wdata <= d;
		bus_write <= 1'b1;
		#1 chk({20'h0, chan_start}, t && d != 0 && m[c][0][0] ? 32'h1 << c : 32'h0);
		if (a[9:2] == 8'hC0) stat &= ~d[11:0];
		if (a[9:2] == 8'hC1) mask = d[11:0];
		if (c < 4'hC) begin
			m[c][fmap[a[5:2]]] = d;
			if (t && d != 0 && m[c][0][0]) begin
				busy[c] = 1'b1;
				cntr[c] = m[c][3];
			end
			if (t && d == 0 && m[c][0][21]) stat[c] = 1'b1;
		end
		@(posedge clk_sys);
		bus_write <= 1'b0;
	endtask : wr
	task rd(input logic [9:0] a);
		@(posedge clk_sys);
		bus_addr <= a;
		bus_read <= 1'b1;
		@(posedge clk_sys);
		bus_read <= 1'b0;
		#1 chk(bus_rdata, mval(a));
		chk({20'h0, chan_busy}, {20'h0, busy});
		chk({31'h0, irq}, {31'h0, |(stat & mask)});
	endtask : rd
	task done(input int c);
		@(posedge clk_sys);
		xfer_done <= 12'h1 << c;
		@(posedge clk_sys);
		xfer_done <= 12'h000;
		if (cntr[c] <= 1) busy[c] = 1'b0;
		else cntr[c]--;
	endtask : done
	task stop_test();
		$display("mismatches %0d comparisons %0d", n_mismatch, comparisons);
		if (n_mismatch == 0 && comparisons > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask : stop_test
	initial begin
		logic [31:0] r, d;
		logic [9:0] a, b;
		for (int c = 0; c < 12; c++) m[c] = '{32'(c) << 11, 32'h0, 32'h0, 32'h0};
		repeat (16) @(posedge clk_sys);
		resetn <= 1'b1;
		for (int i = 0; i < 1024; i += 4) rd(10'(i));
		// Random traffic keeps enable clear, so triggers never start a channel
		repeat (300) begin
			r = xs();
			d = r[1:0] == 2'h0 ? 32'h0 : xs();
			a = {4'(r[9:6] % 13), r[5:2], 2'b00};
			if (fmap[a[5:2]] == 0) d &= 32'h00EF_FFFE;
			wr(a, d);
			rd(a);
			b = {a[9:6], r[15:12], 2'b00};
			rd(b);
		end
		wr(10'h304, 32'h0000_0FFF);
		for (int k = 0; k < 3; k++) begin
			a = 10'(tc[k] * 64 + 16 * (k + 1));
			wr(a + 10'(co[k] & 6'h0F), 32'h2);
			wr(a + 10'hC, 32'h2);
			wr(a, 32'h1);
			wr(a + 10'hC, 32'h2);
			rd(a);
			wr(a, 32'h0);
			rd(a + 10'h4);
			wr(a, 32'h1);
			done(tc[k]);
			rd(a);
			done(tc[k]);
			rd(a);
			wr(a, 32'h0020_0001);
			wr(a + 10'hC, 32'h0);
			rd(10'h300);
			wr(10'h304, 32'h0);
			rd(10'h300);
			wr(10'h300, 32'h0000_0FFF);
			wr(10'h304, 32'h0000_0FFF);
			rd(10'h308);
		end
		stop_test();
	end
endmodule : dma_channel_alias_decode_bench
